// File: hdl/trp_pkg.sv
// constants shared by the touch report target port
package trp_pkg;
    // bus identity and direction bit
    localparam logic [6:0] TRP_TARGET_ADDR = 7'h4B; // own 7-bit target address
    localparam logic TRP_DIR_READ = 1'b1; // lsb of address byte, 1 selects read
    // location map
    localparam logic [15:0] TRP_CNT_ADDR = 16'h012E; // pending report count, read only
    localparam logic [15:0] TRP_SLOT_BASE = 16'h012F; // first byte of the report slot
    localparam logic [15:0] TRP_SLOT_LAST = 16'h0136; // last byte of the report slot
    localparam logic [15:0] TRP_SCR_BASE = 16'h0000; // base of the writable scratch area
    localparam int TRP_SLOT_BYTES = 8; // bytes in one report slot
    localparam int TRP_SCR_BYTES = 16; // bytes in the scratch area
    localparam int TRP_SLOTS = 4; // reports held pending
    // byte values
    localparam logic [7:0] TRP_NO_REPORT_ID = 8'hFF; // id shown when nothing pending
    localparam logic [7:0] TRP_ZERO_BYTE = 8'h00; // filler and reset byte
    // bit counting within a frame
    localparam logic [3:0] TRP_BITS_DONE = 4'h8; // eight data bits taken
    localparam logic [3:0] TRP_BITS_NONE = 4'h0; // start of a byte
    localparam logic [1:0] TRP_BYTE_PLO = 2'h0; // pointer low byte expected
    localparam logic [1:0] TRP_BYTE_PHI = 2'h1; // pointer high byte expected
    localparam logic [1:0] TRP_BYTE_DATA = 2'h2; // data bytes from here on
    // protocol phase
    typedef enum logic [2:0] {
        TRP_IDLE,
        TRP_ADDR,
        TRP_ACK,
        TRP_WRB,
        TRP_RDB,
        TRP_RACK
    } trp_phase_e;
endpackage

// File: hdl/trp_sync.sv
// two flip-flop level synchroniser, one bit per lane
`timescale 1ns/10ps
module trp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // at least one lane
    if (W < 1) begin : g_bad_w
        $error("trp_sync: W must be at least 1");
    end
    typedef struct packed {
        logic [W-1:0] meta; // first stage, read only by the second
        logic [W-1:0] q; // second stage
    } trp_sync_s;
    trp_sync_s s_r;
    trp_sync_s s_nxt;

    // shift the lanes through both stages
    always_comb begin
        s_nxt.meta = d;
        s_nxt.q = s_r.meta;
    end

    // registers, cleared on reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.q;
endmodule

// File: hdl/trp_scl_sampler.sv
// link side: samples the data line on each rising clock edge of the link
`timescale 1ns/10ps
module trp_scl_sampler (
    input wire logic scl_clk,
    input wire logic nrst,
    input wire logic sda_i,
    output logic bit_o,
    output logic tog_o
);
    typedef struct packed {
        logic bit_v; // data line at the last rising edge
        logic tog; // flips once per rising edge
    } trp_smp_s;
    trp_smp_s s_r;
    trp_smp_s s_nxt;

    // capture the bit and mark the edge by a toggle
    always_comb begin
        s_nxt.bit_v = sda_i;
        s_nxt.tog = ~s_r.tog;
    end

    // link clock may stop between frames; state just holds then
    always_ff @(posedge scl_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bit_o = s_r.bit_v;
    assign tog_o = s_r.tog;
endmodule

// File: hdl/trp_top.sv
// touch report target port: pointer, report queue and pending line
`timescale 1ns/10ps
module trp_top
    import trp_pkg::*;
#(
    parameter int SLOTS = TRP_SLOTS,
    parameter int SCR_BYTES = TRP_SCR_BYTES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic report_pending_n_o,
    output logic report_pending_n_oe,
    input wire logic rpt_valid,
    input wire logic [63:0] rpt_data,
    output logic rpt_ready
);
    // queue depth must be a power of two, count must fit in a byte
    if (SLOTS < 2 || SLOTS > 128 || (SLOTS & (SLOTS - 1)) != 0) begin : g_bad_slots
        $error("trp_top: SLOTS must be a power of two from 2 to 128");
    end
    // scratch index must fit the pointer offset
    if (SCR_BYTES < 1 || SCR_BYTES > 256) begin : g_bad_scr
        $error("trp_top: SCR_BYTES must be 1 to 256");
    end

    // derived widths and steps
    localparam int HW = $clog2(SLOTS); // width of a queue index
    localparam int SW = (SCR_BYTES > 1) ? $clog2(SCR_BYTES) : 1; // scratch index width
    localparam logic [HW-1:0] HEAD_STEP = HW'(1); // queue index step
    localparam logic [3:0] BIT_STEP = 4'h1; // bit counter step
    localparam logic [7:0] CNT_STEP = 8'h01; // pending count step
    localparam logic [15:0] PTR_STEP = 16'h0001; // pointer step
    localparam logic [7:0] CNT_FULL = 8'(SLOTS); // count when queue is full
    localparam logic [15:0] SCR_END = 16'(SCR_BYTES); // first location past scratch

    // timing budget, all in system clock cycles
    // pins pass two sync stages, so line events show about three cycles late
    // a bit is used one cycle after its toggle lands, so the bit lane has settled
    // the host must keep the bus clock high and low for several cycles each
    // a bus clock faster than a few system clocks would lose toggles

    typedef struct packed {
        trp_phase_e st; // protocol phase
        logic [3:0] bitcnt; // bits taken in this byte
        logic [7:0] sh; // byte shifter, both directions
        logic is_rd; // transfer direction
        logic [1:0] bytecnt; // write byte position
        logic [15:0] ptr; // address pointer
        logic [15:0] sptr; // pointer value to return to
        logic sda_oe; // pulling the data line low
        logic scl_p; // previous synced clock line
        logic sda_p; // previous synced data line
        logic tog_p; // previous synced edge toggle
        logic rise_pend; // rising edge seen, bit settles one cycle
        logic chg_oe; // pulling the pending line low
        logic rdy; // report input can take one
        logic [HW-1:0] head; // oldest report
        logic [7:0] cnt; // reports pending
        logic [SLOTS-1:0][63:0] slots; // report storage
        logic [SCR_BYTES-1:0][7:0] scr; // writable scratch bytes
    } trp_top_s;
    trp_top_s s_r;
    trp_top_s s_nxt;

    // crossing outputs of the synchroniser
    logic [3:0] syn_q; // synced clock, data, sampled bit, toggle
    logic smp_bit; // bit caught on the link clock
    logic smp_tog; // toggle from the link clock

    // link domain sampler
    // the data line is caught on the bus clock itself, where it is settled,
    // and the captured bit and an edge toggle cross over beside the raw clock and data pins
    trp_scl_sampler u_smp (
        .scl_clk(scl_clk),
        .nrst(nrst),
        .sda_i(sda_i),
        .bit_o(smp_bit),
        .tog_o(smp_tog)
    );

    // bring pins and sampler state into the system clock domain
    trp_sync #(.W(4)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d({scl_clk, sda_i, smp_bit, smp_tog}),
        .q(syn_q)
    );

    // byte shown at a location for a read
    // slot bytes come from the oldest report; empty queue shows the no-report id in the first slot byte, zero in the rest
    // unmapped locations read as zero
    function automatic logic [7:0] rd_byte(input trp_top_s s);
        logic [2:0] off;
        logic [63:0] rep;
        logic [15:0] soff;
        off = 3'(s.ptr - TRP_SLOT_BASE);
        rep = s.slots[s.head];
        soff = s.ptr - TRP_SCR_BASE;
        rd_byte = TRP_ZERO_BYTE;
        if (s.ptr == TRP_CNT_ADDR) begin
            rd_byte = s.cnt;
        end else if (s.ptr >= TRP_SLOT_BASE && s.ptr <= TRP_SLOT_LAST) begin
            if (s.cnt != TRP_ZERO_BYTE) begin
                rd_byte = rep[{off, 3'h0} +: 8];
            end else if (off == 3'h0) begin
                rd_byte = TRP_NO_REPORT_ID;
            end
        end else if (soff < SCR_END) begin
            rd_byte = s.scr[SW'(soff)];
        end
    endfunction

    // protocol, pointer and queue
    // priority: start, then stop, then rising edge, then falling edge
    // start and stop may interrupt any phase; stop restores the pointer, start only during a read
    // rising edges take bits but never move the data pull; of the edges, only falling ones move it
    // so the pull never changes while the bus clock is high
    // pointer start value is caught at our address acknowledge
    // and moved to the loaded value when the two pointer bytes arrive
    // a report leaves the queue only when its last byte is acknowledged
    // so a nack on that byte leaves it to be read again
    always_comb begin
        logic scl_s;
        logic sda_s;
        logic bit_s;
        logic start_c;
        logic stop_c;
        logic fall_c;
        logic push_c;
        logic pop_c;
        logic [7:0] rb;
        logic [15:0] woff;
        scl_s = syn_q[3];
        sda_s = syn_q[2];
        bit_s = syn_q[1];
        // hold everything unless a branch below moves it
        s_nxt = s_r;
        pop_c = 1'b0;
        push_c = rpt_valid && s_r.rdy;
        // read byte for the current pointer, used on falling edges
        rb = rd_byte(s_r);
        woff = s_r.ptr - TRP_SCR_BASE;
        // line events from synced levels
        // start: data falls while the clock stays high
        // stop: data rises while the clock stays high
        start_c = scl_s && s_r.scl_p && s_r.sda_p && !sda_s;
        stop_c = scl_s && s_r.scl_p && !s_r.sda_p && sda_s;
        fall_c = s_r.scl_p && !scl_s;
        s_nxt.scl_p = scl_s;
        s_nxt.sda_p = sda_s;
        s_nxt.tog_p = syn_q[0];
        // toggle edge is a rising link clock edge; use the bit a cycle later
        s_nxt.rise_pend = syn_q[0] ^ s_r.tog_p;

        if (start_c) begin
            // start or repeated start: a read in progress ends here
            if (s_r.st != TRP_IDLE && s_r.is_rd) begin
                s_nxt.ptr = s_r.sptr;
            end
            s_nxt.st = TRP_ADDR;
            s_nxt.bitcnt = TRP_BITS_NONE;
            s_nxt.bytecnt = TRP_BYTE_PLO;
            s_nxt.sda_oe = 1'b0;
        end else if (stop_c) begin
            // stop ends any addressed transfer
            if (s_r.st != TRP_IDLE) begin
                s_nxt.ptr = s_r.sptr;
            end
            s_nxt.st = TRP_IDLE;
            s_nxt.sda_oe = 1'b0;
        end else if (s_r.rise_pend) begin
            // rising link clock edge: take a bit or close a byte
            unique case (s_r.st)
                TRP_ADDR, TRP_WRB, TRP_RDB: begin
                    if (s_r.bitcnt < TRP_BITS_DONE) begin
                        s_nxt.sh = {s_r.sh[6:0], bit_s};
                        s_nxt.bitcnt = s_r.bitcnt + BIT_STEP;
                    end
                end
                TRP_ACK: begin
                    // our acknowledge clocked out
                    s_nxt.bitcnt = TRP_BITS_NONE;
                    s_nxt.st = s_r.is_rd ? TRP_RDB : TRP_WRB;
                end
                TRP_RACK: begin
                    // ninth rise of a read byte carries the host answer
                    s_nxt.bitcnt = TRP_BITS_NONE;
                    if (bit_s) begin
                        // host nack: back to the start value
                        s_nxt.ptr = s_r.sptr;
                        s_nxt.st = TRP_IDLE;
                    end else begin
                        s_nxt.st = TRP_RDB;
                        if (s_r.ptr == TRP_SLOT_LAST) begin
                            // one report consumed if any is pending, wrap to the slot start
                            s_nxt.ptr = TRP_SLOT_BASE;
                            pop_c = s_r.cnt != TRP_ZERO_BYTE;
                        end else begin
                            s_nxt.ptr = s_r.ptr + PTR_STEP;
                        end
                    end
                end
                TRP_IDLE: begin
                    // not addressed: ignore the bus
                end
            endcase
        end else if (fall_c) begin
            // falling link clock edge: drive or release the data line
            unique case (s_r.st)
                TRP_ADDR: begin
                    // eight bits in: compare the address, note the direction
                    if (s_r.bitcnt == TRP_BITS_DONE) begin
                        if (s_r.sh[7:1] == TRP_TARGET_ADDR) begin
                            s_nxt.sda_oe = 1'b1;
                            s_nxt.is_rd = s_r.sh[0] == TRP_DIR_READ;
                            s_nxt.sptr = s_r.ptr;
                            s_nxt.st = TRP_ACK;
                        end else begin
                            s_nxt.st = TRP_IDLE;
                        end
                    end
                end
                TRP_WRB: begin
                    if (s_r.bitcnt == TRP_BITS_DONE) begin
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.st = TRP_ACK;
                        if (s_r.bytecnt == TRP_BYTE_PLO) begin
                            s_nxt.ptr = {s_r.ptr[15:8], s_r.sh};
                            s_nxt.sptr = {s_r.ptr[15:8], s_r.sh};
                            s_nxt.bytecnt = TRP_BYTE_PHI;
                        end else if (s_r.bytecnt == TRP_BYTE_PHI) begin
                            s_nxt.ptr = {s_r.sh, s_r.ptr[7:0]};
                            s_nxt.sptr = {s_r.sh, s_r.ptr[7:0]};
                            s_nxt.bytecnt = TRP_BYTE_DATA;
                        end else begin
                            // only scratch is writable; count and slot are read only
                            // the byte lands before the acknowledge, so a stop loses nothing
                            if (woff < SCR_END) begin
                                s_nxt.scr[SW'(woff)] = s_r.sh;
                            end
                            s_nxt.ptr = s_r.ptr + PTR_STEP;
                        end
                    end else begin
                        s_nxt.sda_oe = 1'b0;
                    end
                end
                TRP_RDB: begin
                    if (s_r.bitcnt == TRP_BITS_NONE) begin
                        // bit count zero: a fresh byte is due
                        // load the byte at the pointer, msb first
                        s_nxt.sh = rb;
                        s_nxt.sda_oe = !rb[7];
                    end else if (s_r.bitcnt == TRP_BITS_DONE) begin
                        // release for the host acknowledge
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st = TRP_RACK;
                    end else begin
                        s_nxt.sda_oe = !s_r.sh[7];
                    end
                end
                TRP_ACK, TRP_RACK, TRP_IDLE: begin
                    // nothing driven on this edge
                end
            endcase
        end

        // report queue: new reports in, consumed ones out
        // push and pop in one cycle leave the count as it was
        // the write index is the head plus the count, wrapping in the queue
        if (push_c) begin
            s_nxt.slots[HW'(s_r.head + HW'(s_r.cnt))] = rpt_data;
        end
        if (pop_c) begin
            s_nxt.head = s_r.head + HEAD_STEP;
        end
        if (push_c && !pop_c) begin
            s_nxt.cnt = s_r.cnt + CNT_STEP;
        end else if (pop_c && !push_c) begin
            s_nxt.cnt = s_r.cnt - CNT_STEP;
        end
        // ready drops on the same edge the queue fills
        s_nxt.rdy = s_nxt.cnt != CNT_FULL;
        // pending line low while any report is unread
        s_nxt.chg_oe = s_nxt.cnt != TRP_ZERO_BYTE;
    end

    // state register, idle and empty after reset
    // line history starts low to match the cleared sync stages,
    // so no false start or stop follows reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{
                st: TRP_IDLE,
                bitcnt: TRP_BITS_NONE,
                sh: TRP_ZERO_BYTE,
                is_rd: 1'b0,
                bytecnt: TRP_BYTE_PLO,
                ptr: TRP_CNT_ADDR,
                sptr: TRP_CNT_ADDR,
                sda_oe: 1'b0,
                scl_p: 1'b0,
                sda_p: 1'b0,
                tog_p: 1'b0,
                rise_pend: 1'b0,
                chg_oe: 1'b0,
                rdy: 1'b0,
                head: '0,
                cnt: TRP_ZERO_BYTE,
                slots: '0,
                scr: '0
            };
        end else begin
            s_r <= s_nxt;
        end
    end

    // open-drain pins only ever pull low
    // the value pins stay low; only the enables move
    // the pending enable is a register, so the line never glitches
    assign sda_o = 1'b0;
    assign sda_oe = s_r.sda_oe;
    assign report_pending_n_o = 1'b0;
    assign report_pending_n_oe = s_r.chg_oe;
    assign rpt_ready = s_r.rdy;
endmodule

// File: test/trp_props.sv
// pin checker for the touch report target port
`timescale 1ns/10ps
module trp_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_clk,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic report_pending_n_o,
    input wire logic report_pending_n_oe,
    input wire logic rpt_valid,
    input wire logic [63:0] rpt_data,
    input wire logic rpt_ready
);
    // all checks on the system clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // a report taken by the queue
    sequence push_s;
        rpt_valid && rpt_ready;
    endsequence
    // stop: data rises while clock high
    sequence stop_s;
        scl_clk && $rose(sda_i);
    endsequence
    // pending line only turns on after a push
    AST_PEND_CAUSE: assert property (
        $rose(report_pending_n_oe) |-> $past(rpt_valid && rpt_ready, 1)
        || $past(rpt_valid && rpt_ready, 2) || $past(rpt_valid && rpt_ready, 3))
        else $error("pending line rose without a report");
    // a push into an empty queue raises the line
    AST_PEND_ON: assert property (
        push_s and !report_pending_n_oe |-> ##[1:3] report_pending_n_oe)
        else $error("pending line missed a new report");
    // line only released by bus reading
    AST_PEND_FALL: assert property (
        $fell(report_pending_n_oe) |-> $past(scl_clk, 2) || $past(scl_clk, 4))
        else $error("pending line dropped outside a read");
    // both pins open drain, value low
    AST_OPEN_DRAIN: assert property (
        sda_o == 1'b0 && report_pending_n_o == 1'b0)
        else $error("open drain pin driven high");
    // data held while clock high
    AST_SDA_STABLE: assert property (
        scl_clk && $past(scl_clk) |-> $stable(sda_oe))
        else $error("data changed while clock high");
    // bus left alone after a stop
    AST_STOP_IDLE: assert property (
        stop_s |-> !sda_oe [*8])
        else $error("data pulled after stop");
    // pull starts only in clock low
    AST_ACK_LOW: assert property (
        $rose(sda_oe) |-> !scl_clk)
        else $error("pull began with clock high");
    // a pull stands for at least five cycles
    AST_ACK_HOLD: assert property (
        $rose(sda_oe) |-> sda_oe [*5])
        else $error("pull released too soon");
endmodule

bind trp_top trp_props u_props (.clk(clk), .nrst(nrst), .scl_clk(scl_clk), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .report_pending_n_o(report_pending_n_o),
    .report_pending_n_oe(report_pending_n_oe), .rpt_valid(rpt_valid),
    .rpt_data(rpt_data), .rpt_ready(rpt_ready));

// File: test/trp_host.sv
// host controller model: drives bus clock and data pull
`timescale 1ns/10ps
module trp_host (
    output logic scl,
    output logic pull,
    input wire logic sda
);
    // idle: clock high and still, data released
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // start: data falls while clock high, one per transfer
    task automatic start();
        #37 pull = 1'b0;
        #500 scl = 1'b1;
        #1000 pull = 1'b1;
        #1000 scl = 1'b0;
    endtask
    // nine bits msb first, 1 releases the line
    task automatic bits9(input logic [8:0] o, output logic [8:0] i);
        for (int k = 8; k >= 0; k--) begin
            #500 pull = ~o[k];
            #500 scl = 1'b1;
            #500 i[k] = sda;
            #500 scl = 1'b0;
        end
    endtask
    // stop: data rises while clock high, only at transfer end
    task automatic stop();
        #500 pull = 1'b1;
        #500 scl = 1'b1;
        #1000 pull = 1'b0;
        #1000;
    endtask
endmodule

// File: test/tb.sv
// self-checking bench for the touch report target port
`timescale 1ns/10ps
module tb;
    import trp_pkg::*;
    logic clk = 1'b0; // system clock
    logic nrst = 1'b0; // reset, active low
    logic rpt_valid = 1'b0; // report offer
    logic [63:0] rpt_data = 64'h0; // report body
    logic sda_o, sda_oe, pnd_o, pnd_oe, rpt_ready, scl, pull; // pin sides
    wire sda; // resolved data line, pulled up
    wire pend_n; // resolved pending line, pulled up
    int n_errors = 0;
    int comparisons = 0;
    logic [63:0] q[$]; // reports expected in the queue
    logic [7:0] scr[TRP_SCR_BYTES]; // expected scratch bytes
    logic [15:0] ptr; // expected pointer
    logic [8:0] rx; // bits seen by the host
    assign sda = (sda_oe ? sda_o : 1'b1) & ~pull;
    assign pend_n = pnd_oe ? pnd_o : 1'b1;
    trp_top dut (.clk(clk), .nrst(nrst), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .report_pending_n_o(pnd_o), .report_pending_n_oe(pnd_oe),
        .rpt_valid(rpt_valid), .rpt_data(rpt_data), .rpt_ready(rpt_ready));
    trp_host host (.scl(scl), .pull(pull), .sda(sda));
    // system clock
    initial begin
        forever #50 clk = ~clk;
    end
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic close_out();
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // expected byte at a location
    function automatic logic [7:0] expb(input logic [15:0] p);
        if (p == TRP_CNT_ADDR) return 8'(q.size());
        if (p >= TRP_SLOT_BASE && p <= TRP_SLOT_LAST) begin
            if (q.size() == 0) return (p == TRP_SLOT_BASE) ? TRP_NO_REPORT_ID : TRP_ZERO_BYTE;
            return q[0][8*(p-TRP_SLOT_BASE) +: 8];
        end
        if (p < TRP_SCR_BYTES) return scr[p[3:0]];
        return TRP_ZERO_BYTE;
    endfunction
    // start and address byte, off the clock edge
    task automatic adr(input logic r, input logic [6:0] a);
        @(posedge clk);
        host.start();
        host.bits9({a, r, 1'b1}, rx);
    endtask
    // pointer set then n random data bytes
    task automatic wr(input logic [15:0] p, input int n);
        logic [7:0] d;
        adr(1'b0, TRP_TARGET_ADDR);
        chk(8'(rx[0]), 8'h00);
        host.bits9({p[7:0], 1'b1}, rx);
        host.bits9({p[15:8], 1'b1}, rx);
        ptr = p;
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            host.bits9({d, 1'b1}, rx);
            chk(8'(rx[0]), 8'h00);
            if (ptr < TRP_SCR_BYTES) scr[ptr[3:0]] = d;
            ptr++;
        end
        host.stop();
        ptr = p;
    endtask
    // read n bytes; nack on the last, or ack all and stop when cut
    task automatic rd(input int n, input logic cut = 1'b0);
        logic [15:0] p0;
        p0 = ptr;
        adr(1'b1, TRP_TARGET_ADDR);
        chk(8'(rx[0]), 8'h00);
        for (int k = 0; k < n; k++) begin
            host.bits9({8'hFF, k == n - 1 && !cut}, rx);
            chk(rx[8:1], expb(ptr));
            if (ptr == TRP_SLOT_LAST) begin
                if ((k < n - 1 || cut) && q.size() > 0) void'(q.pop_front());
                ptr = TRP_SLOT_BASE;
            end else begin
                ptr++;
            end
        end
        host.stop();
        ptr = p0;
    endtask
    // offer one report, held until taken
    task automatic push();
        logic [63:0] d;
        d = {$urandom, $urandom};
        @(posedge clk);
        rpt_valid <= 1'b1;
        rpt_data <= d;
        @(negedge clk);
        while (rpt_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        rpt_valid <= 1'b0;
        q.push_back(d);
    endtask
    // watchdog
    initial begin
        #9000000;
        n_errors++;
        close_out();
    end
    // main sequence
    initial begin
        void'($urandom(19865));
        for (int k = 0; k < TRP_SCR_BYTES; k++) scr[k] = TRP_ZERO_BYTE;
        ptr = TRP_CNT_ADDR;
        repeat (10) @(posedge clk);
        chk({5'h00, sda_oe, pnd_oe, rpt_ready}, 8'h00);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        adr(1'b0, TRP_TARGET_ADDR ^ 7'h01);
        chk(8'(rx[0]), 8'h01);
        host.stop();
        adr(1'b1, TRP_TARGET_ADDR ^ 7'h40);
        chk(8'(rx[0]), 8'h01);
        host.stop();
        chk(8'(pend_n), 8'h01);
        rd(2);
        wr(16'h0003, 3);
        rd(3);
        wr(16'h000E, 3);
        rd(4);
        rd(1);
        wr(TRP_CNT_ADDR, 1);
        rd(1);
        repeat (2) push();
        repeat (4) @(posedge clk);
        chk(8'(pend_n), 8'h00);
        rd(1 + 2 * TRP_SLOT_BYTES + 1);
        chk(8'(pend_n), 8'h01);
        rd(1, 1'b1);
        rd(1);
        repeat (TRP_SLOTS) push();
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(8'(rpt_ready), 8'h00);
        @(posedge clk);
        rpt_valid <= 1'b1;
        repeat (5) @(posedge clk);
        rpt_valid <= 1'b0;
        rd(4);
        chk(8'(pend_n), 8'h00);
        rd(1 + TRP_SLOTS * TRP_SLOT_BYTES + 1);
        chk(8'(pend_n), 8'h01);
        close_out();
    end
endmodule
